// [pif_pkg.sv]
package pif_pkg;
  // Register offsets, byte addresses on the AHB-Lite bus
  localparam logic [7:0] PIF_FLAGS_OFS = 8'h0C;
  localparam logic [7:0] PIF_ENABLES_OFS = 8'h8C;
  localparam logic [7:0] PIF_STATUS_OFS = 8'h90;
  localparam logic [7:0] PIF_MASK_OFS = 8'h94;
  // Bit positions
  localparam int PIF_BIT_TA = 0;
  localparam int PIF_BIT_TB = 1;
  localparam int PIF_BIT_CC = 2;
  localparam int PIF_BIT_SP = 3;
  localparam int PIF_BIT_AD = 6;
  // Implemented bits of flag and enable registers
  localparam logic [7:0] PIF_IMPL_MASK = 8'h4F;
  localparam logic [7:0] PIF_RESET_VAL = 8'h00;
  localparam logic [31:0] PIF_WORD_ZERO = 32'h0000_0000;
  // Status bits of the block's own event register
  localparam int PIF_STS_FLAG = 0;
  localparam int PIF_STS_IRQ = 1;
  localparam logic [1:0] PIF_STS_ZERO = 2'h0;
  // AHB-Lite encodings
  localparam logic [1:0] PIF_HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] PIF_HTRANS_SEQ = 2'h3;
  // Capture/compare modes
  typedef enum logic [1:0] {
    PIF_CC_CAPTURE = 2'h0,
    PIF_CC_COMPARE = 2'h1,
    PIF_CC_PWM = 2'h2,
    PIF_CC_OFF = 2'h3
  } pif_ccmode_e;
endpackage

// [pif_evt_if.sv]
`timescale 1ns/1ps
`default_nettype none
// Bundle between the bus front end and the flag bank
interface pif_evt_if;
  logic [7:0] wr_data; // Write data, low byte
  logic wr_flags; // Write strobe to flag register
  logic wr_enables; // Write strobe to enable register
  logic [7:0] flags; // Current flags
  logic [7:0] enables; // Current enables
  logic irq_req; // Peripheral request toward core
  modport bank (input wr_data, wr_flags, wr_enables,
    output flags, enables, irq_req);
  modport host (output wr_data, wr_flags, wr_enables,
    input flags, enables, irq_req);
endinterface
`default_nettype wire

// [pif_flag_bank.sv]
`timescale 1ns/1ps
`default_nettype none
// Flag and enable registers with event set logic
module pif_flag_bank (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic [7:0] evt_set,
  pif_evt_if.bank bus
);
  import pif_pkg::*;
  // All state in one struct
  typedef struct packed {
    logic [7:0] flags;
    logic [7:0] enables;
  } pif_bank_s;
  pif_bank_s st_r;
  pif_bank_s st_nxt;
  ////////////////////////////////////////////////////////////////////////
  // Next state: a set on the same cycle as a software clear wins
  always_comb begin
    st_nxt = st_r;
    if (bus.wr_enables) begin
      st_nxt.enables = bus.wr_data & PIF_IMPL_MASK; // RL6
    end
    if (bus.wr_flags) begin
      st_nxt.flags = bus.wr_data & PIF_IMPL_MASK; // RL9
    end
    // Events set regardless of enables; clk_en low still blocks them
    st_nxt.flags = st_nxt.flags | (evt_set & PIF_IMPL_MASK); // RL10
  end
  // Register the state; clk_en freezes everything
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_r <= '0; // RL15
    end else if (clk_en) begin
      st_r <= st_nxt;
    end
  end
  assign bus.flags = st_r.flags;
  assign bus.enables = st_r.enables;
  // Any flag with its enable requests an interrupt
  assign bus.irq_req = |(st_r.flags
    & st_r.enables); // RL1 RL2 RL3 RL4 RL5 RL14
  ////////////////////////////////////////////////////////////////////////
  property p_evt_sets;
    @(posedge clk) disable iff (!reset_n)
      (clk_en && evt_set[PIF_BIT_AD]) |=> st_r.flags[PIF_BIT_AD];
  endproperty
  a_evt_sets: assert property (p_evt_sets) // RL8
    else $error("conversion flag not set after event");
  property p_hw_no_clear;
    @(posedge clk) disable iff (!reset_n)
      (clk_en && !bus.wr_flags && st_r.flags[PIF_BIT_TA])
        |=> st_r.flags[PIF_BIT_TA];
  endproperty
  a_hw_no_clear: assert property (p_hw_no_clear) // RL11
    else $error("timer a flag cleared without a write");
  property p_unimpl_zero;
    @(posedge clk) disable iff (!reset_n)
      ((st_r.flags | st_r.enables) & ~PIF_IMPL_MASK) == 8'h00;
  endproperty
  a_unimpl_zero: assert property (p_unimpl_zero) // RL6
    else $error("unimplemented bit became set");
  property p_irq_tie;
    @(posedge clk) disable iff (!reset_n)
      (clk_en && evt_set[PIF_BIT_TB] && !bus.wr_enables
        && st_r.enables[PIF_BIT_TB]) |=> bus.irq_req;
  endproperty
  a_irq_tie: assert property (p_irq_tie) // RL4
    else $error("enabled timer b event gave no request");
  property p_masked;
    @(posedge clk) disable iff (!reset_n)
      (st_r.enables == 8'h00) |-> !bus.irq_req;
  endproperty
  a_masked: assert property (p_masked) // RL14
    else $error("request while all sources masked");
endmodule
`default_nettype wire

// [pif_irq_bank.sv]
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// (RL1) Conversion enable bit masks or allows source
// (RL2) Serial port enable bit masks or allows
// (RL3) Capture/compare enable bit masks or allows
// (RL4) Timer b match enable bit masks or allows
// (RL5) Timer a overflow enable masks or allows
// (RL6) Bits 7,5,4 read zero, ignore writes
// (RL7) Flag register decoded at address 0Ch
// (RL8) Conversion done sets flag bit 6
// (RL9) Flag register readable and writable by software
// (RL10) Flags set regardless of enable bits
// (RL11) Software clears flags; hardware never does
// (RL12) Timer a bit 0, timer b bit 1
// (RL13) Serial bit 3; capcomp bit 2, not PWM
// (RL14) Request when flag and enable both set
// (RL15) All bits reset to zero
module pif_irq_bank (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic clk_en,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize, // Unused: every transfer is one word
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Peripheral event pulses
  input wire logic conv_done_evt,
  input wire logic serial_port_evt,
  input wire logic capcomp_evt,
  input wire pif_pkg::pif_ccmode_e capcomp_mode,
  input wire logic timer_b_match_evt,
  input wire logic timer_a_overflow_evt,
  // Interrupt outputs
  output logic periph_irq_req,
  output logic irq
);
  import pif_pkg::*;
  ////////////////////////////////////////////////////////////////////////
  // All local state in one struct
  typedef struct packed {
    logic ph_valid; // Data phase pending
    logic ph_write; // Pending transfer is a write
    logic [7:0] ph_addr; // Pending address
    logic [31:0] rdata; // Registered read data
    logic [1:0] status; // Sticky block events
    logic [1:0] mask; // Mask for block events
    logic irq_d; // Previous request level for edge
  } pif_top_s;
  pif_top_s st_r;
  pif_top_s st_nxt;
  pif_evt_if bank_if ();
  logic [7:0] evt_set;
  logic addr_ok;
  logic [31:0] rd_mux;
  logic wr_now;
  ////////////////////////////////////////////////////////////////////////
  // Gather the source pulses into flag positions
  always_comb begin
    evt_set = PIF_RESET_VAL;
    evt_set[PIF_BIT_AD] = conv_done_evt; // RL8
    evt_set[PIF_BIT_SP] = serial_port_evt; // RL13
    // PWM mode leaves the capture/compare flag unused
    evt_set[PIF_BIT_CC] = capcomp_evt && (capcomp_mode == PIF_CC_CAPTURE
      || capcomp_mode == PIF_CC_COMPARE); // RL13
    evt_set[PIF_BIT_TB] = timer_b_match_evt; // RL12
    evt_set[PIF_BIT_TA] = timer_a_overflow_evt; // RL12
  end
  pif_flag_bank u_bank (
    .clk(clk),
    .reset_n(reset_n),
    .clk_en(clk_en),
    .evt_set(evt_set),
    .bus(bank_if.bank)
  );
  ////////////////////////////////////////////////////////////////////////
  // Address decode for the data phase
  always_comb begin
    addr_ok = 1'b1;
    rd_mux = PIF_WORD_ZERO;
    unique case (st_r.ph_addr)
      PIF_FLAGS_OFS: begin
        rd_mux[7:0] = bank_if.flags; // RL7
      end
      PIF_ENABLES_OFS: begin
        rd_mux[7:0] = bank_if.enables; // RL6
      end
      PIF_STATUS_OFS: begin
        rd_mux[1:0] = st_r.status;
      end
      PIF_MASK_OFS: begin
        rd_mux[1:0] = st_r.mask;
      end
      default: begin
        // Unmapped: reads zero, writes dropped, still OKAY
        addr_ok = 1'b0;
      end
    endcase
  end
  // Writes land in the data phase, when hwdata is valid
  assign wr_now = clk_en && st_r.ph_valid && st_r.ph_write && addr_ok;
  assign bank_if.wr_data = hwdata[7:0];
  assign bank_if.wr_flags = wr_now
    && (st_r.ph_addr == PIF_FLAGS_OFS); // RL9
  assign bank_if.wr_enables = wr_now
    && (st_r.ph_addr == PIF_ENABLES_OFS); // RL1
  ////////////////////////////////////////////////////////////////////////
  // Bus tracking, read data capture, block status
  always_comb begin
    st_nxt = st_r;
    st_nxt.ph_valid = 1'b0;
    // Read data is sampled one cycle after the address phase
    if (st_r.ph_valid && !st_r.ph_write) begin
      st_nxt.rdata = rd_mux;
    end
    if (hsel && hready && (htrans == PIF_HTRANS_NONSEQ
        || htrans == PIF_HTRANS_SEQ)) begin
      st_nxt.ph_valid = 1'b1;
      st_nxt.ph_write = hwrite;
      st_nxt.ph_addr = haddr;
    end
    if (wr_now && st_r.ph_addr == PIF_MASK_OFS) begin
      st_nxt.mask = hwdata[1:0];
    end
    if (wr_now && st_r.ph_addr == PIF_STATUS_OFS) begin
      // Write one to clear
      st_nxt.status = st_r.status & ~hwdata[1:0];
    end
    // Set wins over clear: any new flag event, new request edge
    if (|evt_set) begin
      st_nxt.status[PIF_STS_FLAG] = 1'b1;
    end
    if (bank_if.irq_req && !st_r.irq_d) begin
      st_nxt.status[PIF_STS_IRQ] = 1'b1;
    end
    st_nxt.irq_d = bank_if.irq_req;
  end
  // State register; held while clk_en is low
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_r <= '0;
    end else if (clk_en) begin
      st_r <= st_nxt;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // Outputs: read data one cycle later than decode would allow,
  // so one wait state is inserted for reads
  logic rd_wait;
  assign rd_wait = st_r.ph_valid && !st_r.ph_write;
  // Held low while clk_en is low: state is frozen then, so an address
  // or write data phase could not be taken and would be lost
  assign hreadyout = clk_en && !rd_wait;
  assign hrdata = st_r.rdata;
  assign hresp = 1'b0;
  assign periph_irq_req = bank_if.irq_req; // RL14
  assign irq = |(st_r.status & st_r.mask);
  ////////////////////////////////////////////////////////////////////////
  property p_flag_read;
    @(posedge clk) disable iff (!reset_n)
      (clk_en && st_r.ph_valid && !st_r.ph_write
        && st_r.ph_addr == PIF_FLAGS_OFS)
        |=> hrdata == {24'h00_0000, $past(bank_if.flags)};
  endproperty
  a_flag_read: assert property (p_flag_read) // RL7
    else $error("flag register read data wrong");
  property p_pwm_no_flag;
    @(posedge clk) disable iff (!reset_n)
      (capcomp_mode == PIF_CC_PWM) |-> !evt_set[PIF_BIT_CC];
  endproperty
  a_pwm_no_flag: assert property (p_pwm_no_flag) // RL13
    else $error("capture flag event in pwm mode");
  property p_sp_req;
    @(posedge clk) disable iff (!reset_n)
      (bank_if.flags[PIF_BIT_SP] && bank_if.enables[PIF_BIT_SP])
        |-> periph_irq_req;
  endproperty
  a_sp_req: assert property (p_sp_req) // RL2
    else $error("serial flag enabled but no request");
  property p_cc_req;
    @(posedge clk) disable iff (!reset_n)
      (bank_if.flags[PIF_BIT_CC] && bank_if.enables[PIF_BIT_CC])
        |-> periph_irq_req;
  endproperty
  a_cc_req: assert property (p_cc_req) // RL3
    else $error("capcomp flag enabled but no request");
  property p_ta_req;
    @(posedge clk) disable iff (!reset_n)
      (clk_en && timer_a_overflow_evt
        && bank_if.enables[PIF_BIT_TA] && !bank_if.wr_enables)
        ##1 1'b1 |-> bank_if.flags[PIF_BIT_TA] && periph_irq_req;
  endproperty
  a_ta_req: assert property (p_ta_req) // RL5
    else $error("timer a overflow gave no request");
  property p_ad_mask;
    @(posedge clk) disable iff (!reset_n)
      (bank_if.flags == 8'h40 && !bank_if.enables[PIF_BIT_AD])
        |-> !periph_irq_req;
  endproperty
  a_ad_mask: assert property (p_ad_mask) // RL1
    else $error("masked conversion flag requested");
  property p_tb_flag;
    @(posedge clk) disable iff (!reset_n)
      (clk_en && timer_b_match_evt) |=> bank_if.flags[PIF_BIT_TB];
  endproperty
  a_tb_flag: assert property (p_tb_flag) // RL12
    else $error("timer b flag not set");
  property p_unmapped;
    @(posedge clk) disable iff (!reset_n)
      (clk_en && st_r.ph_valid && !addr_ok && !st_r.ph_write)
        |=> hrdata == PIF_WORD_ZERO && !hresp;
  endproperty
  a_unmapped: assert property (p_unmapped) // RL6
    else $error("unmapped read not zero");
  ////////////////////////////////////////////////////////////////////////
  // Bus timing checks: a read has one wait state, a write none
  property p_rd_wait;
    @(posedge clk) disable iff (!reset_n)
      (clk_en && hsel && hready && htrans == PIF_HTRANS_NONSEQ && !hwrite)
        |=> !hreadyout;
  endproperty
  a_rd_wait: assert property (p_rd_wait) // RL9
    else $error("read data phase without a wait state");
  // The wait state ends after one cycle unless the clock enable is low
  property p_rd_done;
    @(posedge clk) disable iff (!reset_n)
      (clk_en && rd_wait) |=> (hreadyout || !clk_en);
  endproperty
  a_rd_done: assert property (p_rd_done) // RL9
    else $error("read wait state lasted too long");
  // A write data phase is answered at once
  property p_wr_nowait;
    @(posedge clk) disable iff (!reset_n)
      (clk_en && st_r.ph_valid && st_r.ph_write) |-> hreadyout;
  endproperty
  a_wr_nowait: assert property (p_wr_nowait) // RL9
    else $error("write data phase was stalled");
  // Upper data lanes always read zero
  property p_hi_zero;
    @(posedge clk) disable iff (!reset_n)
      hrdata[31:8] == 24'h00_0000;
  endproperty
  a_hi_zero: assert property (p_hi_zero) // RL6
    else $error("upper read data lanes not zero");
  ////////////////////////////////////////////////////////////////////////
  // Register writes: only implemented bits are kept
  property p_en_write;
    @(posedge clk) disable iff (!reset_n)
      bank_if.wr_enables
        |=> bank_if.enables == ($past(hwdata[7:0]) & PIF_IMPL_MASK);
  endproperty
  a_en_write: assert property (p_en_write) // RL6
    else $error("enable register write kept wrong value");
  // A flag write keeps the value, plus any event of that cycle
  property p_fl_write;
    @(posedge clk) disable iff (!reset_n)
      bank_if.wr_flags |=> bank_if.flags
        == (($past(hwdata[7:0]) | $past(evt_set)) & PIF_IMPL_MASK);
  endproperty
  a_fl_write: assert property (p_fl_write) // RL9
    else $error("flag register write kept wrong value");
  // An unmapped write leaves both registers alone
  property p_unmapped_wr;
    @(posedge clk) disable iff (!reset_n)
      (clk_en && st_r.ph_valid && st_r.ph_write && !addr_ok
        && evt_set == PIF_RESET_VAL)
        |=> $stable(bank_if.flags) && $stable(bank_if.enables);
  endproperty
  a_unmapped_wr: assert property (p_unmapped_wr) // RL7
    else $error("unmapped write changed a register");
  // A low clock enable freezes both registers
  property p_frozen;
    @(posedge clk) disable iff (!reset_n)
      !clk_en |=> $stable(bank_if.flags) && $stable(bank_if.enables);
  endproperty
  a_frozen: assert property (p_frozen) // RL11
    else $error("registers changed while clock enable low");
  ////////////////////////////////////////////////////////////////////////
  // Sources: each event lands in its own flag bit
  property p_sp_flag;
    @(posedge clk) disable iff (!reset_n)
      (clk_en && serial_port_evt) |=> bank_if.flags[PIF_BIT_SP];
  endproperty
  a_sp_flag: assert property (p_sp_flag) // RL13
    else $error("serial flag not set after event");
  // Compare mode counts like capture mode
  property p_cc_flag;
    @(posedge clk) disable iff (!reset_n)
      (clk_en && capcomp_evt && capcomp_mode == PIF_CC_COMPARE)
        |=> bank_if.flags[PIF_BIT_CC];
  endproperty
  a_cc_flag: assert property (p_cc_flag) // RL13
    else $error("compare event did not set capcomp flag");
  // Timer a overflow sets bit 0
  property p_ta_flag;
    @(posedge clk) disable iff (!reset_n)
      (clk_en && timer_a_overflow_evt) |=> bank_if.flags[PIF_BIT_TA];
  endproperty
  a_ta_flag: assert property (p_ta_flag) // RL12
    else $error("timer a flag not set after overflow");
  // A lone masked timer flag raises nothing
  property p_ta_mask;
    @(posedge clk) disable iff (!reset_n)
      (bank_if.flags == 8'h01 && !bank_if.enables[PIF_BIT_TA])
        |-> !periph_irq_req;
  endproperty
  a_ta_mask: assert property (p_ta_mask) // RL5
    else $error("masked timer a flag requested");
  property p_tb_mask;
    @(posedge clk) disable iff (!reset_n)
      (bank_if.flags == 8'h02 && !bank_if.enables[PIF_BIT_TB])
        |-> !periph_irq_req;
  endproperty
  a_tb_mask: assert property (p_tb_mask) // RL4
    else $error("masked timer b flag requested");
  ////////////////////////////////////////////////////////////////////////
  // Block status: events and request edges are sticky
  property p_sts_evt;
    @(posedge clk) disable iff (!reset_n)
      (clk_en && (|evt_set)) |=> st_r.status[PIF_STS_FLAG];
  endproperty
  a_sts_evt: assert property (p_sts_evt) // RL10
    else $error("event did not set status bit");
  property p_sts_edge;
    @(posedge clk) disable iff (!reset_n)
      (clk_en && bank_if.irq_req && !st_r.irq_d)
        |=> st_r.status[PIF_STS_IRQ];
  endproperty
  a_sts_edge: assert property (p_sts_edge) // RL14
    else $error("request edge did not set status bit");
  // With both mask bits clear the level output stays low
  property p_irq_quiet;
    @(posedge clk) disable iff (!reset_n)
      (st_r.mask == PIF_STS_ZERO) |-> !irq;
  endproperty
  a_irq_quiet: assert property (p_irq_quiet) // RL14
    else $error("interrupt raised with mask clear");
endmodule
`default_nettype wire

// [pif_evt_model.sv]
`timescale 1ns/1ps
`default_nettype none
// Peripheral side: each source gives one-cycle event pulses
module pif_evt_model (
  input wire logic clk,
  output var logic conv_done_evt,
  output var logic serial_port_evt,
  output var logic capcomp_evt,
  output var logic timer_b_match_evt,
  output var logic timer_a_overflow_evt
);
  // Quiet until a source fires
  initial begin
    {conv_done_evt, serial_port_evt, capcomp_evt} = 3'h0;
    {timer_b_match_evt, timer_a_overflow_evt} = 2'h0;
  end
  ////////////////////////////////////////////////////////////////////
  // Pulse: bit 4 conversion, 3 serial, 2 capcomp, 1 match, 0 overflow
  // One cycle only; a held level would set the flag again each cycle
  task automatic pulse(input logic [4:0] v);
    @(posedge clk);
    conv_done_evt <= v[4];
    serial_port_evt <= v[3];
    capcomp_evt <= v[2];
    timer_b_match_evt <= v[1];
    timer_a_overflow_evt <= v[0];
    @(posedge clk);
    {conv_done_evt, serial_port_evt, capcomp_evt} <= 3'h0;
    {timer_b_match_evt, timer_a_overflow_evt} <= 2'h0;
  endtask
endmodule
`default_nettype wire

// [testbench.sv]
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import pif_pkg::*;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic hsel = 1'b0;
  logic [7:0] haddr = 8'h00;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [2:0] hsize = 3'h0;
  logic clk_en = 1'b1;
  logic [31:0] hrdata;
  logic hreadyout, hresp, periph_irq_req, irq;
  logic ev_ad, ev_sp, ev_cc, ev_tb, ev_ta;
  pif_ccmode_e capcomp_mode = PIF_CC_CAPTURE;
  int num_errors = 0;
  int n_checks = 0;
  int cyc = 0;
  // Flag position of each model source, index as in pulse()
  int pos [5] = '{PIF_BIT_TA, PIF_BIT_TB, PIF_BIT_CC, PIF_BIT_SP,
    PIF_BIT_AD};
  ////////////////////////////////////////////////////////////////////
  // 40 MHz clock
  always #12.5 clk = ~clk;
  pif_evt_model src (.clk(clk), .conv_done_evt(ev_ad),
    .serial_port_evt(ev_sp), .capcomp_evt(ev_cc),
    .timer_b_match_evt(ev_tb), .timer_a_overflow_evt(ev_ta));
  // Single slave: its hreadyout is the bus hready
  pif_irq_bank dut (.clk(clk), .reset_n(reset_n), .clk_en(clk_en),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .conv_done_evt(ev_ad), .serial_port_evt(ev_sp),
    .capcomp_evt(ev_cc), .capcomp_mode(capcomp_mode),
    .timer_b_match_evt(ev_tb), .timer_a_overflow_evt(ev_ta),
    .periph_irq_req(periph_irq_req), .irq(irq));
  ////////////////////////////////////////////////////////////////////
  task automatic end_of_test();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Wait for hready: looked at on the falling edge, where it is settled,
  // then the rising edge that samples it is let pass
  task automatic wait_rdy(output logic [31:0] rd, output logic rs);
    @(negedge clk);
    while (hreadyout !== 1'b1) begin
      @(negedge clk);
    end
    rd = hrdata;
    rs = hresp;
    @(posedge clk);
  endtask
  // One AHB-Lite single word transfer; waits on hready, no fixed count
  // hsel stays high between calls; htrans IDLE marks no transfer
  task automatic bus(input logic [7:0] a, input logic w,
    input logic [31:0] wd, output logic [31:0] rd, output logic rs);
    logic [31:0] skip_rd;
    logic skip_rs;
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    hsize <= 3'h2;
    htrans <= PIF_HTRANS_NONSEQ;
    wait_rdy(skip_rd, skip_rs);
    htrans <= 2'h0;
    hwdata <= wd;
    wait_rdy(rd, rs);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic rs;
    bus(a, 1'b1, d, rd, rs);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] rd;
    logic rs;
    bus(a, 1'b0, 32'h0000_0000, rd, rs);
    chk(rd, exp);
    chk({31'h0, rs}, 32'h0000_0000);
  endtask
  // Levels are looked at mid-cycle, then the next rising edge is kept
  task automatic req(input logic e);
    @(negedge clk);
    chk({31'h0, periph_irq_req}, {31'h0, e});
    @(posedge clk);
  endtask
  task automatic irqc(input logic e);
    @(negedge clk);
    chk({31'h0, irq}, {31'h0, e});
    @(posedge clk);
  endtask
  ////////////////////////////////////////////////////////////////////
  // Hang guard, well above the some 160 cycles the run needs
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      num_errors++;
      end_of_test();
    end
  end
  initial begin
    repeat (12) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    rchk(PIF_FLAGS_OFS, 32'h0000_0000);
    rchk(PIF_ENABLES_OFS, 32'h0000_0000);
    // Each source: flag sets while masked, request follows the enable
    for (int i = 0; i < 5; i++) begin
      src.pulse(5'h01 << i);
      req(1'b0);
      rchk(PIF_FLAGS_OFS, 32'h1 << pos[i]);
      wr(PIF_ENABLES_OFS, 32'h1 << pos[i]);
      req(1'b1);
      wr(PIF_FLAGS_OFS, 32'h0000_0000);
      req(1'b0);
      wr(PIF_ENABLES_OFS, 32'h0000_0000);
    end
    // Compare mode sets the capcomp flag; PWM and off modes do not
    capcomp_mode <= PIF_CC_COMPARE;
    src.pulse(5'h04);
    rchk(PIF_FLAGS_OFS, 32'h1 << PIF_BIT_CC);
    wr(PIF_FLAGS_OFS, 32'h0000_0000);
    capcomp_mode <= PIF_CC_PWM;
    src.pulse(5'h04);
    rchk(PIF_FLAGS_OFS, 32'h0000_0000);
    capcomp_mode <= PIF_CC_OFF;
    src.pulse(5'h04);
    rchk(PIF_FLAGS_OFS, 32'h0000_0000);
    // Sticky status, mask and level interrupt, write one to clear
    rchk(PIF_STATUS_OFS, 32'h0000_0003);
    wr(PIF_MASK_OFS, 32'h0000_0003);
    irqc(1'b1);
    wr(PIF_STATUS_OFS, 32'h0000_0003);
    irqc(1'b0);
    rchk(PIF_STATUS_OFS, 32'h0000_0000);
    wr(PIF_MASK_OFS, 32'h0000_0002);
    src.pulse(5'h01);
    irqc(1'b0);
    rchk(PIF_MASK_OFS, 32'h0000_0002);
    // Unimplemented bits read zero; software may set flags itself
    wr(PIF_FLAGS_OFS, 32'hFFFF_FFFF);
    rchk(PIF_FLAGS_OFS, 32'h0000_004F);
    wr(PIF_ENABLES_OFS, 32'hFFFF_FFFF);
    rchk(PIF_ENABLES_OFS, 32'h0000_004F);
    req(1'b1);
    irqc(1'b1);
    // Reset in mid-run clears every flag and enable
    reset_n <= 1'b0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    req(1'b0);
    rchk(PIF_FLAGS_OFS, 32'h0000_0000);
    rchk(PIF_ENABLES_OFS, 32'h0000_0000);
    // Unmapped place reads zero and keeps nothing
    wr(8'h40, 32'hFFFF_FFFF);
    rchk(8'h40, 32'h0000_0000);
    rchk(PIF_FLAGS_OFS, 32'h0000_0000);
    // Clock enable low: the bank ignores a conversion pulse
    clk_en <= 1'b0;
    src.pulse(5'h10);
    clk_en <= 1'b1;
    rchk(PIF_FLAGS_OFS, 32'h0000_0000);
    end_of_test();
  end
endmodule
`default_nettype wire
